// [phy_loop_pkg.sv]
`default_nettype none
package phy_loop_pkg;
  // register indices, byte address is four times the index
  localparam logic [4:0]  IDX_BCTRL    = 5'h00;
  localparam logic [4:0]  IDX_BSTAT    = 5'h01;
  localparam logic [4:0]  IDX_MMD_CTL  = 5'h0D;
  localparam logic [4:0]  IDX_MMD_DATA = 5'h0E;
  localparam logic [4:0]  IDX_MODE     = 5'h11;
  localparam logic [4:0]  IDX_SPECIAL  = 5'h12;
  localparam logic [4:0]  IDX_SYMERR   = 5'h1A;
  localparam logic [4:0]  IDX_EVENT    = 5'h1D;
  localparam int          IDX_LSB      = 2;
  localparam int          IDX_MSB      = 6;
  localparam int          MAP_BITS     = 7;
  // basic control fields
  localparam int          B_SRST       = 15;
  localparam int          B_LOOP       = 14;
  localparam int          B_SPEED      = 13;
  localparam int          B_ANEN       = 12;
  localparam int          B_PD         = 11;
  localparam int          B_ISO        = 10;
  localparam int          B_ANRST      = 9;
  localparam int          B_DUP        = 8;
  localparam int          B_COLT       = 7;
  localparam logic [15:0] CTRL_RW      = 16'h7D80;
  localparam logic [15:0] CTRL_SC      = 16'h8200;
  localparam logic [15:0] CTRL_RST     = 16'h3100;
  // basic status fields
  localparam logic [15:0] BSTAT_ABIL   = 16'h7800;
  localparam int          B_RFAULT     = 4;
  localparam int          B_LINK       = 2;
  // mode control/status, special modes, event register
  localparam int          B_FARLOOP    = 9;
  localparam int          B_READY_SS   = 15;
  localparam int          B_EVT_WC     = 0;
  localparam int          B_EVT_WAC    = 1;
  localparam logic [4:0]  PHYAD_RST    = 5'h00;
  // indirect access
  localparam logic [1:0]  FN_ADDR      = 2'h0;
  localparam int          FN_INC_BIT   = 1;
  localparam logic [4:0]  MMD_DEV      = 5'h03;
  // bus answers
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage
`default_nettype wire

// [phy_loop_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_loop_regs #(
  parameter int ADDR_W      = 7,
  parameter int LOOP_STAGES = 4,
  parameter int MMD_WORDS   = 8
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        RMII_MODE,
  input  wire logic [3:0]  MAC_TXD,
  input  wire logic        MAC_TXEN,
  output logic [3:0]       MAC_RXD,
  output logic             MAC_RXDV,
  output logic             MAC_CRS,
  output logic             MAC_COL,
  input  wire logic [3:0]  LINE_RXD,
  input  wire logic        LINE_RXDV,
  input  wire logic        LINE_CRS,
  input  wire logic        LINE_COL,
  output logic [3:0]       LINE_TXD,
  output logic             LINE_TXEN,
  output logic             TX_POWER_ON,
  input  wire logic        REMOTE_FAULT,
  input  wire logic        LINK_OK,
  input  wire logic        SYMBOL_ERR,
  input  wire logic        EVENT_IN,
  output logic             SPEED_100,
  output logic             FULL_DUPLEX,
  output logic             AN_ENABLE,
  output logic             AN_RESTART,
  output logic             POWER_DOWN,
  output logic [4:0]       PHY_ADDR
);

  localparam int MMD_AW = (MMD_WORDS > 1) ? $clog2(MMD_WORDS) : 1;

  if (ADDR_W < phy_loop_pkg::MAP_BITS || LOOP_STAGES < 2 ||
      MMD_WORDS < 2 || MMD_WORDS != (1 << MMD_AW)) begin : g_bad_param
    $error("phy_loop_regs: unsupported parameter value");
  end

  typedef struct packed {
    logic                        aw_got;
    logic                        aw_ok;
    logic [4:0]                  aw_idx;
    logic                        w_got;
    logic [15:0]                 wdata;
    logic [15:0]                 wmask;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [15:0]                 rdata;
    logic [15:0]                 ctrl;
    logic                        rf_lh;
    logic                        link_ll;
    logic                        far_loop;
    logic [1:0]                  mmd_fn;
    logic [4:0]                  mmd_dev;
    logic [15:0]                 mmd_addr;
    logic [MMD_WORDS-1:0][15:0]  mmd_mem;
    logic [15:0]                 sym_cnt;
    logic                        evt_wc;
    logic                        evt_wac;
    logic                        ready_ss;
    logic [4:0]                  phy_addr;
    logic [LOOP_STAGES-1:0][4:0] pipe;
    logic [3:0]                  mac_rxd;
    logic                        mac_rxdv;
    logic                        mac_crs;
    logic                        mac_col;
    logic [3:0]                  line_txd;
    logic                        line_txen;
    logic                        tx_pwr;
  } state_type;

  state_type    q;
  state_type    n;
  logic         rd_now;
  logic [4:0]   rd_idx;
  logic         rd_ok;
  logic [15:0]  rd_val;
  logic [15:0]  wd;
  logic [15:0]  wm;
  logic [4:0]   loop_out;
  logic         near;
  logic         far;
  logic         quiet;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [4:0] idx;
    idx = addr[phy_loop_pkg::IDX_MSB:phy_loop_pkg::IDX_LSB];
    is_mapped = (addr >> phy_loop_pkg::MAP_BITS) == '0 &&
                (idx == phy_loop_pkg::IDX_BCTRL ||
                 idx == phy_loop_pkg::IDX_BSTAT ||
                 idx == phy_loop_pkg::IDX_MMD_CTL ||
                 idx == phy_loop_pkg::IDX_MMD_DATA ||
                 idx == phy_loop_pkg::IDX_MODE ||
                 idx == phy_loop_pkg::IDX_SPECIAL ||
                 idx == phy_loop_pkg::IDX_SYMERR ||
                 idx == phy_loop_pkg::IDX_EVENT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = q;
    rd_now   = ARVALID & q.arready;
    rd_idx   = ARADDR[phy_loop_pkg::IDX_MSB:phy_loop_pkg::IDX_LSB];
    rd_ok    = is_mapped(ARADDR);
    rd_val   = 16'h0000;
    wd       = q.wdata;
    wm       = q.wmask;
    loop_out = q.pipe[LOOP_STAGES-1];

    // software reset spares the address field
    if (q.ctrl[phy_loop_pkg::B_SRST]) begin
      n.ctrl     = phy_loop_pkg::CTRL_RST;
      n.far_loop = 1'b0;
      n.mmd_fn   = phy_loop_pkg::FN_ADDR;
      n.mmd_dev  = 5'h00;
      n.mmd_addr = 16'h0000;
      n.sym_cnt  = 16'h0000;
      n.evt_wc   = 1'b0;
      n.evt_wac  = 1'b0;
    end
    n.ctrl[phy_loop_pkg::B_ANRST] = 1'b0;
    n.ready_ss = 1'b1;

    // read data and read side effects
    if (rd_idx == phy_loop_pkg::IDX_BCTRL) begin
      rd_val = q.ctrl & (phy_loop_pkg::CTRL_RW | phy_loop_pkg::CTRL_SC);
    end else if (rd_idx == phy_loop_pkg::IDX_BSTAT) begin
      rd_val = phy_loop_pkg::BSTAT_ABIL;
      rd_val[phy_loop_pkg::B_RFAULT] = q.rf_lh;
      rd_val[phy_loop_pkg::B_LINK]   = q.link_ll;
    end else if (rd_idx == phy_loop_pkg::IDX_MMD_CTL) begin
      rd_val = {q.mmd_fn, 14'h0000};
    end else if (rd_idx == phy_loop_pkg::IDX_MMD_DATA) begin
      rd_val = (q.mmd_fn == phy_loop_pkg::FN_ADDR) ? q.mmd_addr
             : q.mmd_mem[q.mmd_addr[MMD_AW-1:0]];
    end else if (rd_idx == phy_loop_pkg::IDX_MODE) begin
      rd_val[phy_loop_pkg::B_FARLOOP] = q.far_loop;
    end else if (rd_idx == phy_loop_pkg::IDX_SPECIAL) begin
      rd_val[phy_loop_pkg::B_READY_SS] = q.ready_ss;
      rd_val[4:0] = q.phy_addr;
    end else if (rd_idx == phy_loop_pkg::IDX_SYMERR) begin
      rd_val = q.sym_cnt;
    end else if (rd_idx == phy_loop_pkg::IDX_EVENT) begin
      rd_val[phy_loop_pkg::B_EVT_WC]  = q.evt_wc;
      rd_val[phy_loop_pkg::B_EVT_WAC] = q.evt_wac;
    end

    // latch bits: a fresh condition always beats the read clear
    if (rd_now && rd_ok && rd_idx == phy_loop_pkg::IDX_BSTAT) begin
      n.rf_lh   = REMOTE_FAULT;
      n.link_ll = LINK_OK;
    end else begin
      n.rf_lh   = q.rf_lh | REMOTE_FAULT;
      n.link_ll = q.link_ll & LINK_OK;
    end
    if (rd_now && rd_ok && rd_idx == phy_loop_pkg::IDX_SYMERR) begin
      n.sym_cnt = {15'h0000, SYMBOL_ERR};
    end else if (SYMBOL_ERR && !(&q.sym_cnt)) begin
      n.sym_cnt = q.sym_cnt + 16'h0001;
    end

    // write address and data are taken in either order
    if (AWVALID && q.awready) begin
      n.aw_got = 1'b1;
      n.aw_ok  = is_mapped(AWADDR);
      n.aw_idx = AWADDR[phy_loop_pkg::IDX_MSB:phy_loop_pkg::IDX_LSB];
    end
    if (WVALID && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = WDATA[15:0];
      n.wmask = lane_mask(WSTRB);
    end

    if (q.aw_got && q.w_got) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = q.aw_ok ? phy_loop_pkg::RESP_OKAY
                         : phy_loop_pkg::RESP_SLVERR;
      if (!q.aw_ok) begin
        n.bresp = phy_loop_pkg::RESP_SLVERR;
      end else if (q.aw_idx == phy_loop_pkg::IDX_BCTRL) begin
        // reserved and read-only bits are outside both masks
        n.ctrl = merge(n.ctrl, wd, wm & phy_loop_pkg::CTRL_RW)
               | (wd & wm & phy_loop_pkg::CTRL_SC);
      end else if (q.aw_idx == phy_loop_pkg::IDX_MMD_CTL) begin
        if (wm[15]) begin
          n.mmd_fn = wd[15:14];
        end
        if (wm[0]) begin
          n.mmd_dev = wd[4:0];
        end
      end else if (q.aw_idx == phy_loop_pkg::IDX_MMD_DATA) begin
        if (q.mmd_fn == phy_loop_pkg::FN_ADDR) begin
          n.mmd_addr = merge(q.mmd_addr, wd, wm);
        end else begin
          if (q.mmd_dev == phy_loop_pkg::MMD_DEV) begin
            n.mmd_mem[q.mmd_addr[MMD_AW-1:0]] =
              merge(q.mmd_mem[q.mmd_addr[MMD_AW-1:0]], wd, wm);
          end
          if (q.mmd_fn[phy_loop_pkg::FN_INC_BIT]) begin
            n.mmd_addr = q.mmd_addr + 16'h0001;
          end
        end
      end else if (q.aw_idx == phy_loop_pkg::IDX_MODE) begin
        if (wm[phy_loop_pkg::B_FARLOOP]) begin
          n.far_loop = wd[phy_loop_pkg::B_FARLOOP];
        end
      end else if (q.aw_idx == phy_loop_pkg::IDX_SPECIAL) begin
        if (wm[0]) begin
          n.phy_addr = wd[4:0];
        end
        if (wm[phy_loop_pkg::B_READY_SS] && !wd[phy_loop_pkg::B_READY_SS])
        begin
          n.ready_ss = 1'b0;
        end
      end else if (q.aw_idx == phy_loop_pkg::IDX_EVENT) begin
        if (|wm) begin
          n.evt_wac = 1'b0;
        end
        if (wm[phy_loop_pkg::B_EVT_WC] && wd[phy_loop_pkg::B_EVT_WC]) begin
          n.evt_wc = 1'b0;
        end
      end
      // status and counter registers ignore writes
    end
    // events arriving with a clear still land
    n.evt_wc  = n.evt_wc | EVENT_IN;
    n.evt_wac = n.evt_wac | SYMBOL_ERR;

    if (q.bvalid && BREADY) begin
      n.bvalid = 1'b0;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;

    if (rd_now) begin
      n.rvalid = 1'b1;
      n.rdata  = rd_ok ? rd_val : 16'h0000;
      n.rresp  = rd_ok ? phy_loop_pkg::RESP_OKAY
                       : phy_loop_pkg::RESP_SLVERR;
    end else if (q.rvalid && RREADY) begin
      n.rvalid = 1'b0;
    end
    n.arready = !n.rvalid;

    // data paths; the pipe stands in for the coding and media stages
    n.pipe = {q.pipe[LOOP_STAGES-2:0], {MAC_TXEN, MAC_TXD}};
    near   = q.ctrl[phy_loop_pkg::B_LOOP];
    // far loop needs the reduced interface; near loop wins over it
    far    = q.far_loop && RMII_MODE && !near;
    quiet  = q.ctrl[phy_loop_pkg::B_ISO] || far;

    if (quiet) begin
      n.mac_rxd  = 4'h0;
      n.mac_rxdv = 1'b0;
      n.mac_crs  = 1'b0;
      n.mac_col  = 1'b0;
    end else if (near) begin
      n.mac_rxd  = loop_out[3:0];
      n.mac_rxdv = loop_out[4];
      n.mac_crs  = loop_out[4];
      n.mac_col  = q.ctrl[phy_loop_pkg::B_COLT] & MAC_TXEN;
    end else begin
      n.mac_rxd  = LINE_RXD;
      n.mac_rxdv = LINE_RXDV;
      n.mac_crs  = LINE_CRS;
      n.mac_col  = LINE_COL;
    end

    if (near || q.ctrl[phy_loop_pkg::B_PD]) begin
      n.line_txd  = 4'h0;
      n.line_txen = 1'b0;
      n.tx_pwr    = 1'b0;
    end else if (far) begin
      n.line_txd  = LINE_RXD;
      n.line_txen = LINE_RXDV;
      n.tx_pwr    = 1'b1;
    end else begin
      n.line_txd  = MAC_TXD;
      n.line_txen = MAC_TXEN;
      n.tx_pwr    = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      q            <= '0;
      q.ctrl       <= phy_loop_pkg::CTRL_RST;
      q.ready_ss   <= 1'b1;
      q.phy_addr   <= phy_loop_pkg::PHYAD_RST;
    end else if (CE) begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign AWREADY     = q.awready;
  assign WREADY      = q.wready;
  assign BVALID      = q.bvalid;
  assign BRESP       = q.bresp;
  assign ARREADY     = q.arready;
  assign RVALID      = q.rvalid;
  assign RRESP       = q.rresp;
  assign RDATA       = {16'h0000, q.rdata};
  assign MAC_RXD     = q.mac_rxd;
  assign MAC_RXDV    = q.mac_rxdv;
  assign MAC_CRS     = q.mac_crs;
  assign MAC_COL     = q.mac_col;
  assign LINE_TXD    = q.line_txd;
  assign LINE_TXEN   = q.line_txen;
  assign TX_POWER_ON = q.tx_pwr;
  assign SPEED_100   = q.ctrl[phy_loop_pkg::B_SPEED];
  assign FULL_DUPLEX = q.ctrl[phy_loop_pkg::B_DUP];
  assign AN_ENABLE   = q.ctrl[phy_loop_pkg::B_ANEN];
  assign AN_RESTART  = q.ctrl[phy_loop_pkg::B_ANRST];
  assign POWER_DOWN  = q.ctrl[phy_loop_pkg::B_PD];
  assign PHY_ADDR    = q.phy_addr;

endmodule
`default_nettype wire

// [phy_loop_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_loop_regs_sva #(
  parameter int ADDR_W = 7
) (
  input wire logic              CORE_CLK,
  input wire logic              RST,
  input wire logic              CE,
  input wire logic              AWVALID,
  input wire logic              AWREADY,
  input wire logic              WVALID,
  input wire logic              WREADY,
  input wire logic [1:0]        BRESP,
  input wire logic              BVALID,
  input wire logic              BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic [31:0]       RDATA,
  input wire logic [1:0]        RRESP,
  input wire logic              RVALID,
  input wire logic              RREADY,
  input wire logic              LINE_TXEN,
  input wire logic              TX_POWER_ON,
  input wire logic              POWER_DOWN,
  input wire logic              AN_RESTART
);
  // one bit per implemented register index
  localparam logic [31:0] MAPPED = 32'h2406_6003;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  //////////////////////////////////////////////////////////////////////////
  sequence wr_take;
    CE && AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence rd_take;
    CE && ARVALID && ARREADY;
  endsequence
  sequence unmapped_rd;
    rd_take ##0 !MAPPED[ARADDR[6:2]];
  endsequence
  //////////////////////////////////////////////////////////////////////////
  a_write_answer: assert property (wr_take |-> ##2 BVALID)
    else $error("write answer not two cycles after both taken");
  a_read_answer: assert property (rd_take |=> RVALID)
    else $error("read answer late");
  a_unmapped_read: assert property (unmapped_rd |=>
    RRESP == phy_loop_pkg::RESP_SLVERR && RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_bresp_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  a_rdata_held: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  a_write_refused: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write accepted with response pending");
  a_read_refused: assert property (RVALID |-> !ARREADY)
    else $error("read accepted with data pending");
  a_tx_quiet: assert property (!TX_POWER_ON |-> !LINE_TXEN)
    else $error("transmit enable with transmitters off");
  a_pd_quiet: assert property (CE && POWER_DOWN |=> !TX_POWER_ON)
    else $error("transmitters on during power down");
  a_restart_pulse: assert property (AN_RESTART |=> !AN_RESTART)
    else $error("restart bit did not clear itself");
endmodule
bind phy_loop_regs phy_loop_regs_sva #(.ADDR_W(ADDR_W)) phy_loop_regs_sva_inst (
  .CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
  .RREADY(RREADY), .LINE_TXEN(LINE_TXEN), .TX_POWER_ON(TX_POWER_ON),
  .AN_RESTART(AN_RESTART), .POWER_DOWN(POWER_DOWN));
`default_nettype wire

// [mac_line_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module mac_line_peer (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  run,
  output logic [3:0] mac_txd,
  output logic       mac_txen,
  output logic [3:0] line_rxd,
  output logic       line_rxdv,
  output logic       line_crs,
  output logic       line_col
);
  logic [3:0] cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // nibbles move every cycle so a sample shifted by less than 16 cycles never matches
  assign mac_txd   = cnt_reg;
  assign line_rxd  = {cnt_reg[0], cnt_reg[3:1]} ^ 4'h9;
  // frames pause now and then to exercise valid edges
  assign mac_txen  = run & ~(cnt_reg[3] & cnt_reg[2]);
  assign line_rxdv = run & ~(cnt_reg[3] & ~cnt_reg[2]);
  assign line_crs  = line_rxdv;
  // odd collisions so a col routed from the wrong side shows up
  assign line_col  = line_rxdv & cnt_reg[1] & cnt_reg[0];
endmodule
`default_nettype wire

// [phy_loop_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_loop_regs_test;
  logic        clk, rst, awv, wv, bready, arv, rready, rmii, run, txen;
  logic        rfault, link, symerr, evt, awr, wr_rdy, bv, arr, rv, spd;
  logic        mrxdv, mcol, ltxen, txpwr, restart, lrxdv, lcrs, lcol;
  logic        mcrs, fdup, anen, pdn, ce;
  logic [6:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, th;
  logic [3:0]  wstrb, txd, mrxd, ltxd, lrxd, lh;
  logic [1:0]  bresp, rresp, blast, rres, lch;
  logic [4:0]  phy_addr;
  logic [15:0] rval;
  logic [7:0]  tvh;
  int          miscompares, checks_done, cyc;
  phy_loop_regs #(.LOOP_STAGES(4)) phy_loop_regs_inst (
    .CORE_CLK(clk), .RST(rst), .CE(ce), .AWADDR(awaddr),
    .AWVALID(awv), .AWREADY(awr), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wv), .WREADY(wr_rdy), .BRESP(bresp), .BVALID(bv),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arv), .ARREADY(arr),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rv), .RREADY(rready),
    .RMII_MODE(rmii), .MAC_TXD(txd), .MAC_TXEN(txen), .MAC_RXD(mrxd),
    .MAC_RXDV(mrxdv), .MAC_CRS(mcrs), .MAC_COL(mcol), .LINE_RXD(lrxd),
    .LINE_RXDV(lrxdv), .LINE_CRS(lcrs), .LINE_COL(lcol), .LINE_TXD(ltxd),
    .LINE_TXEN(ltxen), .TX_POWER_ON(txpwr), .REMOTE_FAULT(rfault),
    .LINK_OK(link), .SYMBOL_ERR(symerr), .EVENT_IN(evt), .SPEED_100(spd),
    .FULL_DUPLEX(fdup), .AN_ENABLE(anen), .AN_RESTART(restart),
    .POWER_DOWN(pdn),
    .PHY_ADDR(phy_addr));
  mac_line_peer mac_line_peer_inst (.clk(clk), .rst(rst), .run(run),
    .mac_txd(txd), .mac_txen(txen), .line_rxd(lrxd), .line_rxdv(lrxdv),
    .line_crs(lcrs), .line_col(lcol));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  // input history, oldest nibble highest; also the hang guard
  always @(posedge clk) begin
    th <= {th[27:0], txd};
    tvh <= {tvh[6:0], txen};
    lh <= lrxd;
    lch <= {lcrs, lcol};
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= {i, 2'h0};
    wdata <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (bv) begin
        done = 1'b1;
        blast = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [4:0] i);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= {i, 2'h0};
    arv <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        done = 1'b1;
        rval = rdata[15:0];
        rres = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic rdc(input logic [4:0] i, input logic [15:0] e);
    rd(i);
    chk("read data", e, rval);
    chk("read resp", phy_loop_pkg::RESP_OKAY, rres);
  endtask
  // mode 0 normal, 1 near loop, 2 far loop; settle first
  task automatic look(input int m, input logic ct);
    repeat (6) @(posedge clk);
    repeat (8) begin
      @(posedge clk);
      if (m == 0) begin
        chk("mac rxd", lh, mrxd);
        chk("line txd", th[3:0], ltxd);
        chk("line txen", tvh[0], ltxen);
        chk("mac crs", lch[1], mcrs);
        chk("mac col", lch[0], mcol);
      end else if (m == 1) begin
        chk("loop rxd", th[19:16], mrxd);
        chk("loop rxdv", tvh[4], mrxdv);
        chk("loop crs", tvh[4], mcrs);
        chk("loop txen", 1'b0, ltxen);
        chk("tx power", 1'b0, txpwr);
        chk("loop col", ct & tvh[0], mcol);
      end else begin
        chk("far txd", lh, ltxd);
        chk("far rxdv", 1'b0, mrxdv);
        chk("far rxd", 4'h0, mrxd);
      end
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {awv, wv, bready, arv, rready, rmii, run, rfault, symerr, evt} = 10'h000;
    {awaddr, araddr, wdata} = 46'h0;
    wstrb = 4'h3;
    link = 1'b1;
    ce = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    rdc(phy_loop_pkg::IDX_BCTRL, 16'h3100);
    chk("duplex", 1'b1, fdup);
    chk("an enable", 1'b1, anen);
    chk("power down", 1'b0, pdn);
    rd(phy_loop_pkg::IDX_BSTAT);
    wr(phy_loop_pkg::IDX_BSTAT, 16'h8020);
    rdc(phy_loop_pkg::IDX_BSTAT, 16'h7804);
    rfault <= 1'b1;
    link <= 1'b0;
    repeat (2) @(posedge clk);
    rfault <= 1'b0;
    link <= 1'b1;
    rdc(phy_loop_pkg::IDX_BSTAT, 16'h7810);
    rdc(phy_loop_pkg::IDX_BSTAT, 16'h7804);
    rfault <= 1'b1;
    rdc(phy_loop_pkg::IDX_BSTAT, 16'h7814);
    rdc(phy_loop_pkg::IDX_BSTAT, 16'h7814);
    rfault <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      wr(phy_loop_pkg::IDX_BCTRL, s[0] ? 16'h2100 : 16'h0100);
      chk("speed", s[0], spd);
      look(0, 1'b0);
    end
    chk("write resp", phy_loop_pkg::RESP_OKAY, blast);
    wr(phy_loop_pkg::IDX_BCTRL, 16'h4100);
    look(1, 1'b0);
    wr(phy_loop_pkg::IDX_BCTRL, 16'h4180);
    look(1, 1'b1);
    rdc(phy_loop_pkg::IDX_BCTRL, 16'h4180);
    rmii <= 1'b1;
    wr(phy_loop_pkg::IDX_BCTRL, 16'h0100);
    wr(phy_loop_pkg::IDX_MODE, 16'h0200);
    look(2, 1'b0);
    rmii <= 1'b0;
    look(0, 1'b0);
    wr(phy_loop_pkg::IDX_BCTRL, 16'h0300);
    chk("restart", 1'b1, restart);
    rdc(phy_loop_pkg::IDX_BCTRL, 16'h0100);
    wr(phy_loop_pkg::IDX_BCTRL, 16'h0900);
    repeat (2) @(posedge clk);
    chk("power down", 1'b1, pdn);
    chk("pd power", 1'b0, txpwr);
    chk("pd txen", 1'b0, ltxen);
    wr(phy_loop_pkg::IDX_BCTRL, 16'h0100);
    repeat (3) begin
      @(posedge clk);
      symerr <= 1'b1;
      evt <= 1'b1;
      @(posedge clk);
      symerr <= 1'b0;
      evt <= 1'b0;
    end
    rdc(phy_loop_pkg::IDX_EVENT, 16'h0003);
    wr(phy_loop_pkg::IDX_EVENT, 16'h0000);
    rdc(phy_loop_pkg::IDX_EVENT, 16'h0001);
    wr(phy_loop_pkg::IDX_EVENT, 16'h0001);
    rdc(phy_loop_pkg::IDX_EVENT, 16'h0000);
    wr(phy_loop_pkg::IDX_SYMERR, 16'h0000);
    rdc(phy_loop_pkg::IDX_SYMERR, 16'h0003);
    rdc(phy_loop_pkg::IDX_SYMERR, 16'h0000);
    wr(phy_loop_pkg::IDX_MMD_CTL, 16'h0003);
    wr(phy_loop_pkg::IDX_MMD_DATA, 16'h0002);
    wr(phy_loop_pkg::IDX_MMD_CTL, 16'h4003);
    wr(phy_loop_pkg::IDX_MMD_DATA, 16'h5AA5);
    rdc(phy_loop_pkg::IDX_MMD_DATA, 16'h5AA5);
    wr(phy_loop_pkg::IDX_MMD_CTL, 16'h0003);
    rdc(phy_loop_pkg::IDX_MMD_DATA, 16'h0002);
    wr(phy_loop_pkg::IDX_MMD_CTL, 16'h8003);
    wr(phy_loop_pkg::IDX_MMD_DATA, 16'h1234);
    wr(phy_loop_pkg::IDX_MMD_CTL, 16'h0003);
    rdc(phy_loop_pkg::IDX_MMD_DATA, 16'h0003);
    wr(phy_loop_pkg::IDX_SPECIAL, 16'h0005);
    rdc(phy_loop_pkg::IDX_SPECIAL, 16'h8005);
    wr(phy_loop_pkg::IDX_BCTRL, 16'h8000);
    repeat (4) @(posedge clk);
    rdc(phy_loop_pkg::IDX_BCTRL, 16'h3100);
    rdc(phy_loop_pkg::IDX_SPECIAL, 16'h8005);
    chk("phy addr", 5'h05, phy_addr);
    // freeze: line data keeps moving, the receive output must not
    ce <= 1'b0;
    @(posedge clk);
    rval = {12'h000, mrxd};
    repeat (3) begin
      @(posedge clk);
      chk("frozen rxd", rval, {12'h000, mrxd});
    end
    ce <= 1'b1;
    wr(5'h02, 16'h0000);
    chk("unmapped write", phy_loop_pkg::RESP_SLVERR, blast);
    rd(5'h1F);
    chk("unmapped read", phy_loop_pkg::RESP_SLVERR, rres);
    chk("unmapped data", 16'h0000, rval);
    close_out();
  end
endmodule
`default_nettype wire
